// file: src/async_periph_consts.vh
// Purpose: constants for the asynchronous byte-wide configuration port
// Assumes: 10 MHz system clock, one config clock period = twice CONFIG_SHIFT_CLOCK_DIV system clocks
// Notes: all timing in system clock cycles
`ifndef ASYNC_PERIPH_CONSTS_VH
`define ASYNC_PERIPH_CONSTS_VH
`define MODE_ASYNC_PERIPH 3'h5
`define CONFIG_SHIFT_CLOCK_DIV 4'h2
`define BYTE_BITS 4'h8
`define LAST_BYTE_BITS 4'h7
`define STATUS_LOW_BITS 7'h7f
`define ST_IDLE 2'h0
`define ST_SHIFT 2'h1
`define ST_PARK 2'h2
`endif

// file: src/edge_sync.v
// Purpose: three-stage synchroniser with agreement filter
// Assumes: input is asynchronous to clk_i
// Notes: output changes once stages two and three agree
`timescale 1ns/1ps
module edge_sync #(
	parameter RESET_VAL = 1'b0
) (
	input wire clk_i,
	input wire reset_n_i,
	input wire din_i,
	output wire dout_o
);
	reg s1_ff;
	reg s2_ff;
	reg s3_ff;
	reg out_ff;

	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s1_ff <= RESET_VAL;
			s2_ff <= RESET_VAL;
			s3_ff <= RESET_VAL;
			out_ff <= RESET_VAL;
		end else begin
			s1_ff <= din_i;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			if (s2_ff == s3_ff) begin
				out_ff <= s3_ff;
			end
		end
	end

	assign dout_o = out_ff;
endmodule // edge_sync

// file: src/async_periph_config_port.v
// Purpose: byte-wide asynchronous peripheral configuration port
// Assumes: host strobes are asynchronous; config clock derived from clk_i
// Notes: final byte flagged by last_byte_i; that byte shifts seven bits, all others eight
`timescale 1ns/1ps
`include "async_periph_consts.vh"
module async_periph_config_port #(
	parameter CONFIG_SHIFT_CLOCK_DIV = `CONFIG_SHIFT_CLOCK_DIV
) (
	input wire clk_i,
	input wire reset_n_i,
	input wire [2:0] mode_select_pins_i,
	input wire init_done_i,
	input wire write_strobe_n_i,
	input wire read_strobe_n_i,
	input wire chip_select_low_active_i,
	input wire chip_select_high_active_i,
	input wire [7:0] data_i,
	input wire last_byte_i,
	input wire own_bits_done_i,
	output wire [7:0] data_o,
	output wire data_oe_o,
	output wire ready_busy_o,
	output wire ready_busy_oe_o,
	output wire config_shift_clock_o,
	output wire config_data_o,
	output wire config_data_valid_o,
	output wire chain_data_o,
	output wire startup_done_o
);
	// ---------------------------------------------------------------
	// mode and strobe decode
	// ---------------------------------------------------------------
	wire mode_on;
	wire write_cond;
	wire read_cond;
	wire write_sync;
	reg write_d_ff;
	reg [7:0] latch_ff;
	reg [7:0] hold_ff;

	assign mode_on = (mode_select_pins_i == `MODE_ASYNC_PERIPH);
	assign write_cond = mode_on & ~write_strobe_n_i & ~chip_select_low_active_i & read_strobe_n_i
		& chip_select_high_active_i;
	assign read_cond = mode_on & ~read_strobe_n_i & write_strobe_n_i & ~chip_select_low_active_i
		& chip_select_high_active_i;

	// data sampled while the write is active; stable by the synchronised trailing edge
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			latch_ff <= 8'h00;
		end else if (write_cond) begin
			latch_ff <= data_i;
		end
	end

	edge_sync u_write_sync (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.din_i(write_cond),
		.dout_o(write_sync)
	);

	wire write_end;
	assign write_end = write_d_ff & ~write_sync;

	// ---------------------------------------------------------------
	// config clock generator
	// ---------------------------------------------------------------
	reg [3:0] div_ff;
	reg config_shift_clock_ff;
	wire tick;
	localparam [31:0] DIV_LAST = CONFIG_SHIFT_CLOCK_DIV - 1;
	assign tick = (div_ff == DIV_LAST[3:0]);

	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			div_ff <= 4'h0;
		end else if (tick) begin
			div_ff <= 4'h0;
		end else begin
			div_ff <= div_ff + 4'h1;
		end
	end

	// ---------------------------------------------------------------
	// two-level buffer and shifter
	// ---------------------------------------------------------------
	reg hold_full_ff;
	reg hold_last_ff;
	reg [1:0] state_ff;
	reg [7:0] shift_ff;
	reg [3:0] bits_left_ff;
	reg shift_last_ff;
	reg dout_ff;
	reg valid_ff;
	reg startup_ff;
	reg [1:0] nxt_state;

	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			`ST_IDLE: begin
				if (tick & hold_full_ff) begin
					nxt_state = `ST_SHIFT;
				end
			end
			`ST_SHIFT: begin
				if (tick & config_shift_clock_ff & (bits_left_ff == 4'h1)) begin
					if (shift_last_ff) begin
						nxt_state = `ST_PARK;
					end else if (hold_full_ff) begin
						nxt_state = `ST_SHIFT;
					end else begin
						nxt_state = `ST_IDLE;
					end
				end
			end
			`ST_PARK: begin
				nxt_state = `ST_PARK;
			end
			default: begin
				nxt_state = `ST_IDLE;
			end
		endcase
	end

	wire load_shift;
	assign load_shift = tick & hold_full_ff & ((state_ff == `ST_IDLE) |
		((state_ff == `ST_SHIFT) & config_shift_clock_ff & (bits_left_ff == 4'h1) & ~shift_last_ff));

	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			write_d_ff <= 1'b0;
			hold_ff <= 8'h00;
			hold_full_ff <= 1'b0;
			hold_last_ff <= 1'b0;
			state_ff <= `ST_IDLE;
			shift_ff <= 8'h00;
			bits_left_ff <= 4'h0;
			shift_last_ff <= 1'b0;
			config_shift_clock_ff <= 1'b1;
			dout_ff <= 1'b1;
			valid_ff <= 1'b0;
			startup_ff <= 1'b0;
		end else begin
			write_d_ff <= write_sync;
			valid_ff <= 1'b0;
			state_ff <= nxt_state;
			if (write_end & ~hold_full_ff & init_done_i) begin
				hold_ff <= latch_ff;
				hold_full_ff <= 1'b1;
				hold_last_ff <= last_byte_i;
			end else if (load_shift) begin
				hold_full_ff <= 1'b0;
			end
			if (load_shift) begin
				shift_ff <= hold_ff;
				shift_last_ff <= hold_last_ff;
				bits_left_ff <= hold_last_ff ? `LAST_BYTE_BITS : `BYTE_BITS;
				config_shift_clock_ff <= 1'b0;
				dout_ff <= hold_ff[0];
			end else if (tick & (state_ff == `ST_SHIFT)) begin
				if (!config_shift_clock_ff) begin
					config_shift_clock_ff <= 1'b1;
					valid_ff <= 1'b1;
				end else if (bits_left_ff != 4'h1) begin
					config_shift_clock_ff <= 1'b0;
					shift_ff <= {1'b0, shift_ff[7:1]};
					dout_ff <= shift_ff[1];
					bits_left_ff <= bits_left_ff - 4'h1;
				end else if (shift_last_ff) begin
					startup_ff <= 1'b1;
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	reg [7:0] status_ff;
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			status_ff <= 8'hff;
		end else begin
			status_ff <= {~hold_full_ff, `STATUS_LOW_BITS};
		end
	end

	assign data_o = status_ff;
	assign data_oe_o = read_cond;
	assign ready_busy_o = ~hold_full_ff;
	assign ready_busy_oe_o = mode_on & init_done_i;
	assign config_shift_clock_o = config_shift_clock_ff;
	assign config_data_o = dout_ff;
	assign config_data_valid_o = valid_ff & ~own_bits_done_i;
	assign chain_data_o = dout_ff;
	assign startup_done_o = startup_ff;
endmodule // async_periph_config_port

// file: verification/port_chk_sva.sv
// Purpose: port checks for the config port
// Assumes: bound to the design top, default divider
// Notes: none
`timescale 1ns/1ps
module port_chk (
	input wire clk_i,
	input wire reset_n_i,
	input wire [2:0] mode_select_pins_i,
	input wire init_done_i,
	input wire read_strobe_n_i,
	input wire [7:0] data_o,
	input wire data_oe_o,
	input wire ready_busy_o,
	input wire ready_busy_oe_o,
	input wire config_shift_clock_o,
	input wire config_data_o,
	input wire config_data_valid_o,
	input wire chain_data_o,
	input wire startup_done_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	stat_bits_a: assert property (data_oe_o |-> data_o[6:0] == 7'h7f) else $error("status bits");
	read_cond_a: assert property (data_oe_o |-> !read_strobe_n_i) else $error("read drive");
	pin_drive_a: assert property (ready_busy_oe_o == (init_done_i && mode_select_pins_i == 3'h5)) else $error("drive");
	busy_len_a: assert property ($fell(ready_busy_o) |-> ##[1:36] ready_busy_o) else $error("busy long");
	half_per_a: assert property ($fell(config_shift_clock_o) |=> !config_shift_clock_o ##1 config_shift_clock_o) else $error("half");
	valid_clk_a: assert property (config_data_valid_o |-> config_shift_clock_o) else $error("valid");
	chain_fwd_a: assert property (chain_data_o == config_data_o) else $error("chain");
	park_hold_a: assert property (startup_done_o |=> startup_done_o && config_shift_clock_o && $stable(config_data_o)) else $error("park");
endmodule // port_chk

// file: verification/host_model.sv
// Purpose: microprocessor host writing bytes
// Assumes: rdy_i is the resolved handshake line
// Notes: expected serial bits go to q
`timescale 1ns/1ps
module host_model (
	input wire clk_i,
	input wire rdy_i,
	input wire [7:0] stat_i,
	output logic wr_n_o = 1'b1,
	output logic rd_n_o = 1'b1,
	output logic [7:0] dat_o = 8'h00,
	output logic last_o = 1'b0
);
	logic q[$];
	int n;
	task automatic wr(input logic [7:0] d, input logic l);
		@(negedge clk_i);
		dat_o = d;
		last_o = l;
		wr_n_o = 1'b0;
		n = 0;
		for (int k = 0; k < 60 && n < 4; k++) begin
			@(negedge clk_i);
			n = rdy_i ? n + 1 : 0;
		end
		wr_n_o = 1'b1;
		dat_o = ~d;
		for (int i = 0; i < 8 - l; i++)
			q.push_back(d[i]);
		for (int k = 0; k < 30 && rdy_i; k++)
			@(negedge clk_i);
	endtask
	// write with no handshake watch, spaced beyond ten config clock periods
	task automatic wr_blind(input logic [7:0] d);
		@(negedge clk_i);
		dat_o = d;
		last_o = 1'b0;
		wr_n_o = 1'b0;
		repeat (2) @(negedge clk_i);
		wr_n_o = 1'b1;
		for (int i = 0; i < 8; i++)
			q.push_back(d[i]);
		repeat (50) @(negedge clk_i);
	endtask
	task automatic rd(output logic [7:0] s);
		@(negedge clk_i);
		rd_n_o = 1'b0;
		repeat (3) @(negedge clk_i);
		s = stat_i;
		rd_n_o = 1'b1;
	endtask
endmodule // host_model

// file: verification/tb.sv
// Purpose: self-checking bench, config port
// Assumes: host_model drives the bus
// Notes: serial bits checked at each valid pulse
`timescale 1ns/1ps
module tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [2:0] mode = 3'h5;
	logic init = 1'b0;
	wire wr_n, rd_n, last, oe, rb, rb_oe, config_shift_clock, cdat, vld, done;
	wire [7:0] din, dout;
	wire rb_line = rb_oe ? rb : 1'b1;
	int error_cnt = 0;
	int cmp_count = 0;
	logic [7:0] s;
	always #50 clk = ~clk;
	host_model u_host(.clk_i(clk), .rdy_i(rb_line), .stat_i(dout), .wr_n_o(wr_n), .rd_n_o(rd_n), .dat_o(din),
		.last_o(last));
	async_periph_config_port DUT(.clk_i(clk), .reset_n_i(rst_n), .mode_select_pins_i(mode), .init_done_i(init),
		.write_strobe_n_i(wr_n), .read_strobe_n_i(rd_n), .chip_select_low_active_i(1'b0),
		.chip_select_high_active_i(1'b1), .data_i(din), .last_byte_i(last), .own_bits_done_i(1'b0),
		.data_o(dout), .data_oe_o(oe), .ready_busy_o(rb), .ready_busy_oe_o(rb_oe), .config_shift_clock_o(config_shift_clock),
		.config_data_o(cdat), .config_data_valid_o(vld), .chain_data_o(), .startup_done_o(done));
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] v);
		cmp_count++;
		if (e !== v) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, e, v);
		end
	endtask
	task summarize;
		$display("compares %0d errors %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(negedge clk) if (vld) chk("bit", u_host.q.size() ? {7'h00, u_host.q.pop_front()} : 8'hxx, {7'h00, cdat});
	// run needs about 400 cycles
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		summarize;
	end
	initial begin
		void'($urandom(61560));
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		chk("pull-up", 8'h01, {7'h00, rb_line});
		chk("drive off", 8'h00, {7'h00, rb_oe});
		@(negedge clk);
		init = 1'b1;
		u_host.rd(s);
		chk("status", 8'hff, s);
		mode = 3'h3;
		u_host.wr(8'h5a, 1'b0);
		u_host.q.delete();
		mode = 3'h5;
		repeat (2) u_host.wr_blind(8'($urandom));
		repeat (6) u_host.wr(8'($urandom), 1'b0);
		s = 8'($urandom);
		u_host.wr(s, 1'b1);
		repeat (60) @(negedge clk);
		chk("park data", {7'h00, s[6]}, {7'h00, cdat});
		chk("park clock", 8'h01, {7'h00, config_shift_clock});
		chk("startup", 8'h01, {7'h00, done});
		chk("bits left", 8'h00, 8'(u_host.q.size()));
		summarize;
	end
endmodule // tb
bind async_periph_config_port port_chk u_chk(.*);
